// ===== verilog/rdio_top.sv
// Purpose: dedicated parallel i/o handler of a robot controller
// Assumes: outside controller drives inputs; robot core supplies state values
// Notes:   all outputs registered; request and level pins pass a two-flop synchroniser, numeric_value_in does not
// Function
// RULE1: override request rising edge puts override value on field, raises indicator.
// RULE2: error request rising edge puts error number on field, raises indicator.
// RULE3: jog-enable rising edge validates external jog; jog-valid output shows it.
// RULE4: outside holds 2-bit jog mode; device adopts and reports it.
// RULE5: per-axis plus/minus jog runs while its level input is on.
// RULE6: hand-output status mirrors general outputs 900-907, 910-917, 920-927.
// RULE7: hand-input status mirrors hand inputs in the same three ranges.
// RULE8: hand-error output follows each mechanism's level hand-error input.
// RULE9: pneumatic-error outputs follow the three level pneumatic inputs.
// RULE10: per-mechanism warning once maintenance parts reach replacement time.
// RULE11: up to eight area outputs, set while robot is inside each region.
// RULE12: level inputs keep their function active exactly while on.
// RULE13: edge inputs act on off-to-on only and the state stays afterwards.
// RULE14: field set by input start, input end, output start, output end.
// RULE15: area outputs are a consecutive run of up to eight, start to end.
// RULE16: numeric field is the shared bus for values presented on request.
// RULE17: all outside inputs are synchronised; edges found from successive samples. Here numeric_value_in is only registered once.
`timescale 1ns/10ps
module rdio_top #(
  parameter int FIELD_W = rdio_pkg::FIELD_W,
  parameter int AXES    = rdio_pkg::AXES
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // requests from the outside controller
  input  wire logic                          override_value_request,
  input  wire logic                          error_number_request,
  input  wire logic                          external_jog_enable,
  input  wire logic [rdio_pkg::MODE_W-1:0]   jog_mode_select,
  input  wire logic [AXES-1:0]               jog_plus_in,
  input  wire logic [AXES-1:0]               jog_minus_in,
  input  wire logic [rdio_pkg::MECHS-1:0]    hand_error_mech,
  input  wire logic [rdio_pkg::MECHS-1:0]    pneumatic_error_mech,
  input  wire logic [FIELD_W-1:0]            numeric_value_in,
  // numeric field and area assignment
  input  wire logic [rdio_pkg::CFG_W-1:0]    field_in_start,
  input  wire logic [rdio_pkg::CFG_W-1:0]    field_in_end,
  input  wire logic [rdio_pkg::CFG_W-1:0]    field_out_start,
  input  wire logic [rdio_pkg::CFG_W-1:0]    field_out_end,
  input  wire logic [rdio_pkg::CFG_W-1:0]    area_start,
  input  wire logic [rdio_pkg::CFG_W-1:0]    area_end,
  // robot core state
  input  wire logic [FIELD_W-1:0]            override_value,
  input  wire logic [FIELD_W-1:0]            error_number,
  input  wire logic [23:0]                   general_output_bits,
  input  wire logic [23:0]                   hand_input_bits,
  input  wire logic [rdio_pkg::MECHS-1:0]    parts_due,
  input  wire logic [rdio_pkg::AREAS-1:0]    in_user_region,
  // outputs to the outside controller
  output logic [FIELD_W-1:0]                 numeric_value_field_ff,
  output logic                               override_shown_ff,
  output logic                               error_shown_ff,
  output logic [FIELD_W-1:0]                 numeric_input_value_ff,
  output logic                               jog_valid_ff,
  output logic [rdio_pkg::MODE_W-1:0]        jog_mode_out_ff,
  output logic [AXES-1:0]                    jog_run_plus_ff,
  output logic [AXES-1:0]                    jog_run_minus_ff,
  output logic [23:0]                        hand_output_status_mech_ff,
  output logic [23:0]                        hand_input_status_mech_ff,
  output logic [rdio_pkg::MECHS-1:0]         hand_error_out_ff,
  output logic [rdio_pkg::MECHS-1:0]         pneumatic_error_out_ff,
  output logic [rdio_pkg::MECHS-1:0]         parts_replacement_warning_ff,
  output logic [rdio_pkg::AREAS-1:0]         user_area_ff
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (FIELD_W < 1 || FIELD_W > 32) begin : g_chk_field
    $error("FIELD_W must lie in 1..32");
  end
  if (AXES != rdio_pkg::AXES) begin : g_chk_axes
    $error("AXES must match the packed input layout");
  end

  // mask of n consecutive low bits for a start..end run, capped at max
  function automatic logic [31:0] run_mask(
    input logic [rdio_pkg::CFG_W-1:0] first,
    input logic [rdio_pkg::CFG_W-1:0] last,
    input int                         max
  );
    logic [31:0] n;
    n = 32'(last) - 32'(first) + 32'h1;
    if (last < first)
      run_mask = 32'h0;
    else if (n >= 32'(max))
      run_mask = (max >= 32) ? 32'hFFFFFFFF : ((32'h1 << max) - 32'h1);
    else
      run_mask = (32'h1 << n) - 32'h1;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  rdio_in_if #(.W(rdio_pkg::SYNC_W)) pin_if ();

  // packed in the order fixed by the package positions
  assign pin_if.raw = {pneumatic_error_mech, hand_error_mech, jog_minus_in, jog_plus_in,
                       jog_mode_select, external_jog_enable, error_number_request,
                       override_value_request};  // RULE17

  rdio_sync #(.W(rdio_pkg::SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pins    (pin_if)
  );

  logic                         ovr_rise;
  logic                         err_rise;
  logic                         jog_en_rise;
  logic [rdio_pkg::MODE_W-1:0]  mode_lvl;
  logic [AXES-1:0]              plus_lvl;
  logic [AXES-1:0]              minus_lvl;
  logic [rdio_pkg::MECHS-1:0]   hand_err_lvl;
  logic [rdio_pkg::MECHS-1:0]   air_err_lvl;
  logic [FIELD_W-1:0]           out_mask;
  logic [FIELD_W-1:0]           in_mask;
  logic [rdio_pkg::AREAS-1:0]   area_mask;

  // edge-type inputs use the rise view, level-type the level view
  assign ovr_rise     = pin_if.rise[rdio_pkg::POS_OVR];    // RULE13
  assign err_rise     = pin_if.rise[rdio_pkg::POS_ERR];    // RULE13
  assign jog_en_rise  = pin_if.rise[rdio_pkg::POS_JOGEN];  // RULE13
  assign mode_lvl     = pin_if.lvl[rdio_pkg::POS_MODE +: rdio_pkg::MODE_W];
  assign plus_lvl     = pin_if.lvl[rdio_pkg::POS_PLUS +: AXES];
  assign minus_lvl    = pin_if.lvl[rdio_pkg::POS_MINUS +: AXES];
  assign hand_err_lvl = pin_if.lvl[rdio_pkg::POS_HANDERR +: rdio_pkg::MECHS];
  assign air_err_lvl  = pin_if.lvl[rdio_pkg::POS_AIRERR +: rdio_pkg::MECHS];

  // field widths follow the four assignment numbers, in their fixed order
  assign in_mask   = FIELD_W'(run_mask(field_in_start, field_in_end, FIELD_W));    // RULE14
  assign out_mask  = FIELD_W'(run_mask(field_out_start, field_out_end, FIELD_W));  // RULE14
  assign area_mask = rdio_pkg::AREAS'(run_mask(area_start, area_end, rdio_pkg::AREAS));  // RULE15

  // ----------------------------------------------------------------
  // numeric value field
  // ----------------------------------------------------------------
  rdio_pkg::rdio_sel_t sel_ff;

  // a new request wins over the held one; error wins a tie as more urgent
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      sel_ff <= rdio_pkg::RDIO_SEL_NONE;
    else if (err_rise)
      sel_ff <= rdio_pkg::RDIO_SEL_ERR;  // RULE2
    else if (ovr_rise)
      sel_ff <= rdio_pkg::RDIO_SEL_OVR;  // RULE1
  end

  // field keeps tracking the chosen value so a live override change shows
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      numeric_value_field_ff <= '0;
      override_shown_ff      <= 1'h0;
      error_shown_ff         <= 1'h0;
    end else begin
      unique case (sel_ff)
        rdio_pkg::RDIO_SEL_OVR: begin
          numeric_value_field_ff <= override_value & out_mask;  // RULE16
        end
        rdio_pkg::RDIO_SEL_ERR: begin
          numeric_value_field_ff <= error_number & out_mask;  // RULE16
        end
        rdio_pkg::RDIO_SEL_NONE: begin
          numeric_value_field_ff <= '0;
        end
      endcase
      override_shown_ff <= (sel_ff == rdio_pkg::RDIO_SEL_OVR);  // RULE1
      error_shown_ff    <= (sel_ff == rdio_pkg::RDIO_SEL_ERR);  // RULE2
    end
  end

  // numeric input clipped to its assigned run
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      numeric_input_value_ff <= '0;
    else
      numeric_input_value_ff <= numeric_value_in & in_mask;  // RULE14
  end

  // ----------------------------------------------------------------
  // external jog
  // ----------------------------------------------------------------
  // validity is held once set; only reset withdraws it
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      jog_valid_ff <= rdio_pkg::RST_JOGVLD;
    else if (jog_en_rise)
      jog_valid_ff <= 1'h1;  // RULE3
  end

  // mode is a level selection, reported as adopted
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      jog_mode_out_ff <= rdio_pkg::RST_MODE;
    else
      jog_mode_out_ff <= mode_lvl;  // RULE4
  end

  // opposite directions at once cancel so an axis never gets both
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      jog_run_plus_ff  <= '0;
      jog_run_minus_ff <= '0;
    end else begin
      jog_run_plus_ff  <= {AXES{jog_valid_ff}} & plus_lvl & ~minus_lvl;  // RULE5 RULE12
      jog_run_minus_ff <= {AXES{jog_valid_ff}} & minus_lvl & ~plus_lvl;  // RULE5 RULE12
    end
  end

  // ----------------------------------------------------------------
  // hand status and errors
  // ----------------------------------------------------------------
  // bytes 0,1,2 hold mechanisms 1,2,3 (signals x00..x07 each)
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hand_output_status_mech_ff <= '0;
      hand_input_status_mech_ff  <= '0;
    end else begin
      hand_output_status_mech_ff <= general_output_bits;  // RULE6
      hand_input_status_mech_ff  <= hand_input_bits;      // RULE7
    end
  end

  // errors follow their inputs and drop with them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hand_error_out_ff      <= '0;
      pneumatic_error_out_ff <= '0;
    end else begin
      hand_error_out_ff      <= hand_err_lvl;  // RULE8 RULE12
      pneumatic_error_out_ff <= air_err_lvl;   // RULE9 RULE12
    end
  end

  // ----------------------------------------------------------------
  // warnings and areas
  // ----------------------------------------------------------------
  // areas outside the assigned run stay low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      parts_replacement_warning_ff <= '0;
      user_area_ff                 <= '0;
    end else begin
      parts_replacement_warning_ff <= parts_due;  // RULE10
      user_area_ff                 <= in_user_region & area_mask;  // RULE11 RULE15
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_OVR_SHOWN: assert property ( // RULE1
    ovr_rise && !err_rise |=> ##1 override_shown_ff &&
      numeric_value_field_ff == ($past(override_value) & $past(out_mask))
  ) else $error("override not shown after request");

  AST_ERR_SHOWN: assert property ( // RULE2
    err_rise |=> ##1 error_shown_ff && !override_shown_ff
  ) else $error("error number not shown after request");

  AST_JOG_VALID: assert property ( // RULE3
    jog_en_rise |=> jog_valid_ff
  ) else $error("jog not validated by enable edge");

  AST_JOG_HELD: assert property ( // RULE13
    jog_valid_ff |=> jog_valid_ff
  ) else $error("jog validity lost without reset");

  AST_JOG_MODE: assert property ( // RULE4
    $stable(jog_mode_select) [*4] |-> jog_mode_out_ff == jog_mode_select
  ) else $error("jog mode output does not follow held input");

  AST_JOG_GATED: assert property ( // RULE5
    (jog_run_plus_ff | jog_run_minus_ff) != '0 |-> $past(jog_valid_ff) && (jog_run_plus_ff & jog_run_minus_ff) == '0
  ) else $error("jog runs without validity or both ways");

  AST_HAND_MIRROR: assert property ( // RULE6
    ##1 hand_output_status_mech_ff == $past(general_output_bits) && hand_input_status_mech_ff == $past(hand_input_bits)
  ) else $error("hand status not mirrored");

  AST_HAND_ERR_LVL: assert property ( // RULE8
    hand_error_mech[0] [*4] |-> hand_error_out_ff[0]
  ) else $error("hand error not raised by held input");

  AST_AIR_ERR_OFF: assert property ( // RULE12
    !pneumatic_error_mech[2] [*4] |-> !pneumatic_error_out_ff[2]
  ) else $error("pneumatic error held after input off");

  AST_AREA_CLIP: assert property ( // RULE11
    ##1 user_area_ff == ($past(in_user_region) & $past(area_mask))
  ) else $error("user area output outside assigned run");

  COV_OVR_THEN_ERR: cover property (override_shown_ff ##[1:20] error_shown_ff);
  COV_JOG_RUN:      cover property (jog_valid_ff && jog_run_plus_ff != '0);
  COV_AIR_ERR:      cover property (pneumatic_error_out_ff != '0);

endmodule

// ===== common/rdio_pkg.sv
// Purpose: shared constants and types of the dedicated parallel i/o handler
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   bit positions refer to the packed vector of synchronised inputs
package rdio_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int FIELD_W   = 16;  // numeric value field, bits
  localparam int CFG_W     = 8;   // start/end signal numbers
  localparam int AXES      = 8;   // jog axes
  localparam int MECHS     = 3;   // mechanisms
  localparam int HAND_BITS = 8;   // hand signals per mechanism
  localparam int AREAS     = 8;   // user-designated area outputs
  localparam int MODE_W    = 2;   // jog mode

  // ----------------------------------------------------------------
  // positions in the synchronised input vector
  // ----------------------------------------------------------------
  localparam int POS_OVR     = 0;
  localparam int POS_ERR     = 1;
  localparam int POS_JOGEN   = 2;
  localparam int POS_MODE    = 3;
  localparam int POS_PLUS    = POS_MODE + MODE_W;
  localparam int POS_MINUS   = POS_PLUS + AXES;
  localparam int POS_HANDERR = POS_MINUS + AXES;
  localparam int POS_AIRERR  = POS_HANDERR + MECHS;
  localparam int SYNC_W      = POS_AIRERR + MECHS;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] RST_MODE   = 2'h0;
  localparam logic              RST_JOGVLD = 1'h0;
  localparam int                SYNC_STAGES = 2;  // input flops before use

  // what the numeric value field is carrying
  typedef enum logic [1:0] {
    RDIO_SEL_NONE,
    RDIO_SEL_OVR,
    RDIO_SEL_ERR
  } rdio_sel_t;

endpackage

// ===== common/rdio_in_if.sv
// Purpose: carries raw inputs to the synchroniser and clean samples back
// Assumes: one clock domain
// Notes:   rise is a one-cycle pulse aligned with lvl
`timescale 1ns/10ps
interface rdio_in_if #(parameter int W = rdio_pkg::SYNC_W);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;

  // ----------------------------------------------------------------
  // views
  // ----------------------------------------------------------------
  modport sync (input raw, output lvl, output rise);
  modport user (output raw, input lvl, input rise);
endinterface

// ===== verilog/rdio_sync.sv
// Purpose: two-flop synchroniser with OFF-to-ON detection per bit
// Assumes: inputs come from an outside controller
// Notes:   rise compares second stage with a third, never the first stage
`timescale 1ns/10ps
module rdio_sync #(
  parameter int W = rdio_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // sample path
  rdio_in_if.sync   pins
);

  // the chain below is written out for exactly two stages
  if (W < 1 || rdio_pkg::SYNC_STAGES != 2) begin : g_chk_w
    $error("W must be positive and the chain has two stages");
  end

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  // first stage only feeds the second, keeping metastability contained
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pins.raw;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // level and edge views of the clean sample
  assign pins.lvl  = sync_ff;
  assign pins.rise = sync_ff & ~prev_ff;  // RULE17

endmodule

// ===== verif/rdio_ctrl_model.sv
// Purpose: outside controller model driving the dedicated request pins
// Assumes: pins change only at the falling edge of sys_clk
// Notes:   edge requests are always dropped long enough to be seen low
`timescale 1ns/10ps
module rdio_ctrl_model (
  // clock
  input  wire logic                         sys_clk,
  // request pins
  output logic                              override_value_request,
  output logic                              error_number_request,
  output logic                              external_jog_enable,
  output logic [rdio_pkg::MODE_W-1:0]       jog_mode_select,
  output logic [rdio_pkg::AXES-1:0]         jog_plus_in,
  output logic [rdio_pkg::AXES-1:0]         jog_minus_in,
  output logic [rdio_pkg::MECHS-1:0]        hand_error_mech,
  output logic [rdio_pkg::MECHS-1:0]        pneumatic_error_mech
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // all pins idle low from time zero
  initial begin
    override_value_request = 1'h0;
    error_number_request   = 1'h0;
    external_jog_enable    = 1'h0;
    jog_mode_select        = 2'h0;
    jog_plus_in            = 8'h00;
    jog_minus_in           = 8'h00;
    hand_error_mech        = 3'h0;
    pneumatic_error_mech   = 3'h0;
  end

  // edge request: bit0 override, bit1 error, bit2 jog enable; low tail avoids a merged edge
  task automatic pulse(input logic [2:0] which);
    @(negedge sys_clk);
    {external_jog_enable, error_number_request, override_value_request} = which;
    repeat (3) @(negedge sys_clk);
    {external_jog_enable, error_number_request, override_value_request} = 3'h0;
    repeat (2) @(negedge sys_clk);
  endtask

  // level lines are held steady until the next call
  task automatic set_levels(input logic [1:0] m, input logic [7:0] p, input logic [7:0] n,
                            input logic [2:0] h, input logic [2:0] a);
    @(negedge sys_clk);
    jog_mode_select      = m;
    jog_plus_in          = p;
    jog_minus_in         = n;
    hand_error_mech      = h;
    pneumatic_error_mech = a;
  endtask
endmodule

// ===== verif/rdio_top_bench.sv
// Purpose: self-checking bench of the dedicated parallel i/o handler
// Assumes: partner model drives request pins, bench drives core state
// Notes:   checks are taken at falling edges, well after the answer latency
`timescale 1ns/10ps
module rdio_top_bench;
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  wire         ovr_req, err_req, jog_en;
  wire  [1:0]  mode;
  wire  [7:0]  plus, minus;
  wire  [2:0]  herr, aerr;
  logic [15:0] nvin = 16'h0000, ovr_val = 16'h0000, err_num = 16'h0000;
  logic [7:0]  fis = 8'h00, fie = 8'h0F, fos = 8'h00, foe = 8'h0F, ars = 8'h00, are = 8'h07;
  logic [23:0] gen_bits = 24'h000000, hin_bits = 24'h000000;
  logic [2:0]  due = 3'h0;
  logic [7:0]  region = 8'h00;
  logic [15:0] field, nin;
  logic        ovr_shown, err_shown, jog_valid;
  logic [1:0]  mode_out;
  logic [7:0]  run_p, run_m, area;
  logic [23:0] hout, hin;
  logic [2:0]  herr_o, aerr_o, warn;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  rdio_ctrl_model i_rdio_ctrl_model (.sys_clk(sys_clk), .override_value_request(ovr_req),
    .error_number_request(err_req), .external_jog_enable(jog_en), .jog_mode_select(mode),
    .jog_plus_in(plus), .jog_minus_in(minus), .hand_error_mech(herr), .pneumatic_error_mech(aerr));

  rdio_top i_rdio_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .override_value_request(ovr_req),
    .error_number_request(err_req), .external_jog_enable(jog_en), .jog_mode_select(mode),
    .jog_plus_in(plus), .jog_minus_in(minus), .hand_error_mech(herr), .pneumatic_error_mech(aerr),
    .numeric_value_in(nvin), .field_in_start(fis), .field_in_end(fie), .field_out_start(fos),
    .field_out_end(foe), .area_start(ars), .area_end(are), .override_value(ovr_val),
    .error_number(err_num), .general_output_bits(gen_bits), .hand_input_bits(hin_bits),
    .parts_due(due), .in_user_region(region), .numeric_value_field_ff(field),
    .override_shown_ff(ovr_shown), .error_shown_ff(err_shown), .numeric_input_value_ff(nin),
    .jog_valid_ff(jog_valid), .jog_mode_out_ff(mode_out), .jog_run_plus_ff(run_p),
    .jog_run_minus_ff(run_m), .hand_output_status_mech_ff(hout), .hand_input_status_mech_ff(hin),
    .hand_error_out_ff(herr_o), .pneumatic_error_out_ff(aerr_o),
    .parts_replacement_warning_ff(warn), .user_area_ff(area));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // answer latency is at most four edges; six leaves margin
  task automatic settle;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("field", 24'h0, field);
    chk("shown", 24'h0, {ovr_shown, err_shown, jog_valid});
    $display("test reset done");
  endtask

  task automatic t_override;
    ovr_val = 16'h1234;
    i_rdio_ctrl_model.pulse(3'h1);
    settle;
    chk("field", 24'h1234, field);
    chk("ovr_err", 24'h2, {ovr_shown, err_shown});
    ovr_val = 16'hBEEF;
    repeat (3) @(negedge sys_clk);
    chk("field", 24'hBEEF, field);
    foe = 8'h07;
    repeat (3) @(negedge sys_clk);
    chk("field", 24'h00EF, field);
    foe = 8'h0F;
    $display("test override done");
  endtask

  task automatic t_error;
    err_num = 16'h0A5C;
    i_rdio_ctrl_model.pulse(3'h2);
    settle;
    chk("field", 24'h0A5C, field);
    chk("ovr_err", 24'h1, {ovr_shown, err_shown});
    i_rdio_ctrl_model.pulse(3'h1);
    settle;
    chk("ovr_err", 24'h2, {ovr_shown, err_shown});
    i_rdio_ctrl_model.pulse(3'h3);
    settle;
    chk("tie", 24'h1, {ovr_shown, err_shown});
    $display("test error done");
  endtask

  task automatic t_jog;
    i_rdio_ctrl_model.set_levels(2'h0, 8'h05, 8'h00, 3'h0, 3'h0);
    settle;
    chk("run_p", 24'h0, run_p);
    chk("jog_valid", 24'h0, jog_valid);
    i_rdio_ctrl_model.pulse(3'h4);
    settle;
    chk("jog_valid", 24'h1, jog_valid);
    chk("run_p", 24'h05, run_p);
    i_rdio_ctrl_model.set_levels(2'h0, 8'h05, 8'h84, 3'h0, 3'h0);
    settle;
    chk("run_p", 24'h01, run_p);
    chk("run_m", 24'h80, run_m);
    i_rdio_ctrl_model.set_levels(2'h0, 8'h00, 8'h00, 3'h0, 3'h0);
    settle;
    chk("run", 24'h0, {run_p, run_m});
    for (int m = 3; m >= 0; m--) begin
      i_rdio_ctrl_model.set_levels(m[1:0], 8'h00, 8'h00, 3'h0, 3'h0);
      settle;
      chk("mode", {22'h0, m[1:0]}, mode_out);
    end
    $display("test jog done");
  endtask

  task automatic t_mirror;
    gen_bits = 24'hC3A55A;
    hin_bits = 24'h1E2D3C;
    due = 3'h6;
    region = 8'hFF;
    ars = 8'h02;
    are = 8'h04;
    nvin = 16'hABCD;
    fie = 8'h07;
    settle;
    chk("hout", 24'hC3A55A, hout);
    chk("hin", 24'h1E2D3C, hin);
    chk("warn", 24'h6, warn);
    chk("area", 24'h07, area);
    chk("nin", 24'h00CD, nin);
    region = 8'h00;
    due = 3'h1;
    settle;
    chk("area", 24'h0, area);
    chk("warn", 24'h1, warn);
    $display("test mirror done");
  endtask

  task automatic t_levels;
    i_rdio_ctrl_model.set_levels(2'h0, 8'h00, 8'h00, 3'h5, 3'h6);
    settle;
    chk("herr", 24'h5, herr_o);
    chk("aerr", 24'h6, aerr_o);
    i_rdio_ctrl_model.set_levels(2'h0, 8'h00, 8'h00, 3'h0, 3'h0);
    settle;
    chk("errs", 24'h0, {herr_o, aerr_o});
    $display("test levels done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'h0;
    @(negedge sys_clk);
    t_reset;
    t_override;
    t_error;
    t_jog;
    t_mirror;
    t_levels;
    final_report;
  end
endmodule
